// ===== hdl/tbod_defs.svh
// Constants for the touch button output driver.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef TBOD_DEFS_SVH
`define TBOD_DEFS_SVH
// ==========================================================
// Sizes
`define TBOD_NBTN        10
`define TBOD_CLK_HZ      25000000
// ==========================================================
// Timing, in ms as printed, and derived cycle counts
`define TBOD_PULSE_MS    5
`define TBOD_DLY_NORM_MS 350
`define TBOD_DLY_HIGH_MS 1000
`define TBOD_MS_CYC      ((`TBOD_CLK_HZ) / 1000)
`define TBOD_PULSE_CYC   (`TBOD_PULSE_MS * `TBOD_MS_CYC)
`define TBOD_DLY_NORM_CYC (`TBOD_DLY_NORM_MS * `TBOD_MS_CYC)
`define TBOD_DLY_HIGH_CYC (`TBOD_DLY_HIGH_MS * `TBOD_MS_CYC)
// ==========================================================
// Reset levels and counter width
`define TBOD_OUT_OFF     1'h1
`define TBOD_HOST_OFF    1'h0
`define TBOD_CNT_W       25
`endif

// ===== hdl/tbod_pkg.sv
// Types for the touch button output driver.
// Assumes tbod_defs.svh is visible to the compile.
`include "tbod_defs.svh"
package tbod_pkg;
  typedef logic [`TBOD_NBTN-1:0]  tbod_vec_t;
  typedef logic [`TBOD_CNT_W-1:0] tbod_cnt_t;
  typedef enum logic [1:0] {
    TBOD_WAIT  = 2'h0,
    TBOD_PULSE = 2'h1,
    TBOD_RUN   = 2'h2
  } tbod_phase_t;
endpackage

// ===== hdl/tbod_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
`include "tbod_defs.svh"
module tbod_sync
  import tbod_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      srst,
  input  wire tbod_vec_t din,
  output tbod_vec_t      dout
);
  typedef struct packed {
    tbod_vec_t s1;
    tbod_vec_t s2;
    tbod_vec_t s3;
    tbod_vec_t q;
  } tbod_sync_st_t;
  tbod_sync_st_t st;
  tbod_sync_st_t next_st;
  // ==========================================================
  // Stage chain; s1 feeds only s2
  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Change accepted only when stages two and three agree
    for (int i = 0; i < `TBOD_NBTN; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.q;
endmodule

// ===== hdl/tbod_top.sv
// Touch button output driver: ten touch inputs onto ten
// active-low indicator outputs, plus host outputs and attention.
// Assumes touch status, diag result and host writes arrive as
// levels/pulses; touch inputs are asynchronous pins.
`timescale 1ns/10ps
`include "tbod_defs.svh"
module tbod_top
  import tbod_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      srst,
  input  wire logic      external_reset_in,
  input  wire tbod_vec_t touch_input,
  input  wire tbod_vec_t input_grounded,
  input  wire tbod_vec_t diag_fail,
  input  wire logic      high_noise,
  input  wire tbod_vec_t toggle_en_wdata,
  input  wire logic      toggle_en_we,
  input  wire logic      host_out_wdata_0,
  input  wire logic      host_out_wdata_1,
  input  wire logic      host_out_we,
  input  wire logic      status_read,
  output tbod_vec_t      indicator_output,
  output logic           host_driven_output_0,
  output logic           host_driven_output_1,
  output logic           attention,
  output tbod_vec_t      latched_status
);
  typedef struct packed {
    tbod_phase_t phase;
    tbod_cnt_t   cnt;
    tbod_vec_t   toggle_en;
    tbod_vec_t   toggle_state;
    tbod_vec_t   touch_prev;
    tbod_vec_t   latch;
    tbod_vec_t   ind;
    logic        host0;
    logic        host1;
    logic        attn;
    logic        xr_s1;
    logic        xr_s2;
    logic        xr_s3;
    logic        xr;
  } tbod_st_t;

  tbod_st_t  st;
  tbod_st_t  next_st;
  tbod_vec_t touch_sync;
  tbod_vec_t rise;
  logic      dev_rst;

  // ==========================================================
  // Input synchronisers
  tbod_sync u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .din     (touch_input),
    .dout    (touch_sync)
  );

  assign dev_rst = srst | st.xr;
  assign rise    = touch_sync & ~st.touch_prev & ~input_grounded;

  // Cycle count for the selected power-up delay
  function automatic tbod_cnt_t dly_cyc(input logic hi);
    dly_cyc = hi ? tbod_cnt_t'(`TBOD_DLY_HIGH_CYC) : tbod_cnt_t'(`TBOD_DLY_NORM_CYC);
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    // External reset pin filtered like any pin; s1 feeds only s2
    next_st.xr_s1 = external_reset_in;
    next_st.xr_s2 = st.xr_s1;
    next_st.xr_s3 = st.xr_s2;
    if (st.xr_s2 == st.xr_s3) begin
      next_st.xr = st.xr_s3;
    end
    next_st.touch_prev = touch_sync;
    if (toggle_en_we) begin
      next_st.toggle_en = toggle_en_wdata;
    end
    if (host_out_we) begin
      next_st.host0 = host_out_wdata_0;
      next_st.host1 = host_out_wdata_1;
    end
    next_st.toggle_state = st.toggle_state ^ (rise & st.toggle_en);
    // Read clears, new event wins over clear
    next_st.latch = (status_read ? '0 : st.latch) | rise;
    next_st.attn = |next_st.latch;
    next_st.ind  = '1;
    unique case (st.phase)
      TBOD_WAIT: begin
        if (st.cnt >= dly_cyc(high_noise) - tbod_cnt_t'(1)) begin
          next_st.cnt   = '0;
          next_st.phase = (|(diag_fail & ~input_grounded)) ? TBOD_PULSE : TBOD_RUN;
        end else begin
          next_st.cnt = st.cnt + tbod_cnt_t'(1);
        end
      end
      TBOD_PULSE: begin
        // Single 5 ms low pulse on failed outputs
        next_st.ind = ~(diag_fail & ~input_grounded);
        if (st.cnt >= tbod_cnt_t'(`TBOD_PULSE_CYC) - tbod_cnt_t'(1)) begin
          next_st.phase = TBOD_RUN;
          next_st.cnt   = '0;
          next_st.ind   = '1;
        end else begin
          next_st.cnt = st.cnt + tbod_cnt_t'(1);
        end
      end
      TBOD_RUN: begin
        // Each ungrounded output active low from its own input or toggle state; grounded ones held off
        for (int i = 0; i < `TBOD_NBTN; i++) begin
          if (input_grounded[i]) begin
            next_st.ind[i] = `TBOD_OUT_OFF;
          end else if (st.toggle_en[i]) begin
            next_st.ind[i] = ~next_st.toggle_state[i];
          end else begin
            next_st.ind[i] = ~touch_sync[i];
          end
        end
      end
      default: begin
        next_st.phase = TBOD_RUN;
      end
    endcase
  end

  // ==========================================================
  // State register; pin reset clears it except the pin filter; u_sync clears on srst only
  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      st       <= '0;
      st.ind   <= '1;
      st.host0 <= `TBOD_HOST_OFF;
      st.host1 <= `TBOD_HOST_OFF;
      // Keep the pin filter alive so the reset can release
      st.xr_s1 <= external_reset_in & ~srst;
      st.xr_s2 <= srst ? 1'h0 : st.xr_s1;
      st.xr_s3 <= srst ? 1'h0 : st.xr_s2;
      st.xr    <= srst ? 1'h0 : ((st.xr_s2 == st.xr_s3) ? st.xr_s3 : st.xr);
    end else begin
      st <= next_st;
    end
  end

  assign indicator_output     = st.ind;
  assign host_driven_output_0 = st.host0;
  assign host_driven_output_1 = st.host1;
  assign attention            = st.attn;
  assign latched_status       = st.latch;

  // ==========================================================
  // Checks
  property p_latch_hold;
    @(posedge clk_sys) disable iff (dev_rst)
      (rise != '0) |=> ((st.latch & $past(rise)) == $past(rise));
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("touch event not latched");

  property p_attn;
    @(posedge clk_sys) disable iff (dev_rst)
      (rise != '0) |=> attention;
  endproperty
  a_attn: assert property (p_attn)
    else $error("attention missing after touch");

  property p_host;
    @(posedge clk_sys) disable iff (dev_rst)
      host_out_we |=> (host_driven_output_0 == $past(host_out_wdata_0))
        && (host_driven_output_1 == $past(host_out_wdata_1));
  endproperty
  a_host: assert property (p_host)
    else $error("host output not written");

  property p_ground;
    @(posedge clk_sys) disable iff (dev_rst)
      (st.phase == TBOD_RUN && input_grounded != '0)
        |=> ((indicator_output & $past(input_grounded)) == $past(input_grounded));
  endproperty
  a_ground: assert property (p_ground)
    else $error("grounded input drove output");

  property p_direct;
    @(posedge clk_sys) disable iff (dev_rst)
      (st.phase == TBOD_RUN && !st.toggle_en[0] && !input_grounded[0])
        |=> (indicator_output[0] == ~$past(touch_sync[0]));
  endproperty
  a_direct: assert property (p_direct)
    else $error("output 0 not active low of touch");

  property p_toggle;
    @(posedge clk_sys) disable iff (dev_rst)
      (rise[0] && st.toggle_en[0]) |=> (st.toggle_state[0] != $past(st.toggle_state[0]));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle did not invert");

  property p_toggle_en;
    @(posedge clk_sys) disable iff (dev_rst)
      toggle_en_we |=> (st.toggle_en == $past(toggle_en_wdata));
  endproperty
  a_toggle_en: assert property (p_toggle_en)
    else $error("toggle enable not stored");

  // Counter must advance and stay under the pulse length, so the pulse ends in time
  property p_pulse_end;
    @(posedge clk_sys) disable iff (dev_rst)
      (st.phase == TBOD_PULSE) |=> (st.phase == TBOD_RUN)
        || ((st.cnt == $past(st.cnt) + tbod_cnt_t'(1))
        && (st.cnt < tbod_cnt_t'(`TBOD_PULSE_CYC)));
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("fault pulse too long");

  property p_reset;
    @(posedge clk_sys)
      srst |=> (indicator_output == '1) && !host_driven_output_0
        && !host_driven_output_1 && (st.toggle_state == '0);
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset state wrong");
endmodule

// ===== dv/tbod_host_model.sv
// Host model: writes host levels and toggle enables, reads latch.
// Assumes the device clock; drives only just after rising edges.
`timescale 1ns/10ps
module tbod_host_model
  import tbod_pkg::*;
(
  input  wire logic clk_sys,
  output tbod_vec_t toggle_en_wdata,
  output logic      toggle_en_we,
  output logic      host_out_wdata_0,
  output logic      host_out_wdata_1,
  output logic      host_out_we,
  output logic      status_read
);
  // ==========================================================
  // Idle levels
  initial begin
    toggle_en_wdata = '0;
    toggle_en_we = 1'h0;
    host_out_wdata_0 = 1'h0;
    host_out_wdata_1 = 1'h0;
    host_out_we = 1'h0;
    status_read = 1'h0;
  end
  task automatic wr_host(input logic v0, input logic v1);
    @(posedge clk_sys);
    host_out_wdata_0 <= v0;
    host_out_wdata_1 <= v1;
    host_out_we <= 1'h1;
    @(posedge clk_sys);
    host_out_we <= 1'h0;
  endtask
  task automatic wr_toggle(input tbod_vec_t v);
    @(posedge clk_sys);
    toggle_en_wdata <= v;
    toggle_en_we <= 1'h1;
    @(posedge clk_sys);
    toggle_en_we <= 1'h0;
  endtask
  task automatic rd_status();
    @(posedge clk_sys);
    status_read <= 1'h1;
    @(posedge clk_sys);
    status_read <= 1'h0;
  endtask
endmodule

// ===== dv/test_tbod_top.sv
// Bench for the output driver: resets, then runs scenarios.
// Assumes the power-up wait outlasts the run, so outputs stay off.
`timescale 1ns/10ps
module test_tbod_top;
  import tbod_pkg::*;
  logic      clk_sys = 1'h0;
  logic      srst = 1'h1;
  logic      external_reset_in = 1'h0;
  tbod_vec_t touch_input = '0;
  tbod_vec_t input_grounded = '0;
  tbod_vec_t diag_fail = 10'h004;
  logic      high_noise = 1'h0;
  tbod_vec_t toggle_en_wdata;
  logic      toggle_en_we;
  logic      host_out_wdata_0;
  logic      host_out_wdata_1;
  logic      host_out_we;
  logic      status_read;
  tbod_vec_t indicator_output;
  logic      host_driven_output_0;
  logic      host_driven_output_1;
  logic      attention;
  tbod_vec_t latched_status;
  int        fails = 0;
  int        comparisons = 0;
  // ==========================================================
  // Clock, design and host
  always #20 clk_sys = ~clk_sys;
  tbod_top tbod_top_inst (.clk_sys(clk_sys), .srst(srst),
    .external_reset_in(external_reset_in), .touch_input(touch_input),
    .input_grounded(input_grounded), .diag_fail(diag_fail), .high_noise(high_noise),
    .toggle_en_wdata(toggle_en_wdata), .toggle_en_we(toggle_en_we),
    .host_out_wdata_0(host_out_wdata_0), .host_out_wdata_1(host_out_wdata_1),
    .host_out_we(host_out_we), .status_read(status_read),
    .indicator_output(indicator_output), .host_driven_output_0(host_driven_output_0),
    .host_driven_output_1(host_driven_output_1), .attention(attention),
    .latched_status(latched_status));
  tbod_host_model tbod_host_model_inst (.clk_sys(clk_sys),
    .toggle_en_wdata(toggle_en_wdata), .toggle_en_we(toggle_en_we),
    .host_out_wdata_0(host_out_wdata_0), .host_out_wdata_1(host_out_wdata_1),
    .host_out_we(host_out_we), .status_read(status_read));
  // ==========================================================
  // Shared helpers
  task automatic check(input tbod_vec_t seen, input tbod_vec_t exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Touch held four edges so the agreement filter keeps it
  task automatic poke(input tbod_vec_t v);
    @(posedge clk_sys);
    touch_input <= v;
    repeat (4) @(posedge clk_sys);
    touch_input <= '0;
    cyc(8);
  endtask
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check(indicator_output, '1); // toggles off, outputs high
    check(tbod_vec_t'({host_driven_output_1, host_driven_output_0}), '0); // host off
    check(tbod_vec_t'({attention}), '0); // quiet attention
    check(latched_status, '0); // latch empty
    $display("t_reset done");
  endtask
  task automatic t_host();
    for (int i = 0; i < 4; i++) begin
      tbod_host_model_inst.wr_host(i[0], i[1]);
      #1;
      check(tbod_vec_t'({host_driven_output_1, host_driven_output_0}), tbod_vec_t'(i));
    end
    tbod_host_model_inst.wr_toggle(10'h155); // Enables held per button
    $display("t_host done");
  endtask
  task automatic t_latch();
    poke(10'h008);
    check(latched_status, 10'h008); // brief touch kept alone
    check(tbod_vec_t'({attention}), 10'h001); // attention raised
    check(indicator_output, '1); // no drive before delay ends
    tbod_host_model_inst.rd_status();
    cyc(3);
    check(latched_status, '0); // read clears latch
    check(tbod_vec_t'({attention}), '0); // attention drops
    $display("t_latch done");
  endtask
  task automatic t_ground();
    @(posedge clk_sys);
    input_grounded <= 10'h020;
    poke(10'h021);
    check(latched_status, 10'h001); // grounded input ignored
    tbod_host_model_inst.rd_status();
    input_grounded <= '0;
    cyc(3);
    $display("t_ground done");
  endtask
  task automatic t_external_reset_in();
    tbod_host_model_inst.wr_host(1'h1, 1'h1);
    poke(10'h200);
    @(posedge clk_sys);
    external_reset_in <= 1'h1;
    repeat (6) @(posedge clk_sys);
    external_reset_in <= 1'h0;
    cyc(8);
    check(latched_status, '0); // pin reset clears latch
    check(tbod_vec_t'({attention}), '0); // attention cleared
    check(indicator_output, '1); // outputs back off
    check(tbod_vec_t'({host_driven_output_1, host_driven_output_0}), '0);
    $display("t_external_reset_in done");
  endtask
  // ==========================================================
  // Main sequence and watchdog; run is about 80 cycles
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'h0;
    cyc(1);
    t_reset();
    t_host();
    t_latch();
    t_ground();
    t_external_reset_in();
    conclude();
  end
  initial begin
    #(40 * 4000);
    fails++;
    conclude();
  end
endmodule
